// >>> rtl/sfb_pkg.sv
package sfb_pkg;
  // Register byte offsets on the APB port
  localparam logic [7:0] SFB_CTRL_OFF   = 8'h00;
  localparam logic [7:0] SFB_UCFG_OFF   = 8'h04;
  localparam logic [7:0] SFB_FROP_OFF   = 8'h08;
  localparam logic [7:0] SFB_CLEN_OFF   = 8'h0c;
  localparam logic [7:0] SFB_CMDL_OFF   = 8'h10;
  localparam logic [7:0] SFB_CMDH_OFF   = 8'h14;
  localparam logic [7:0] SFB_RSPL_OFF   = 8'h18;
  localparam logic [7:0] SFB_RSPH_OFF   = 8'h1c;
  localparam logic [7:0] SFB_STAT_OFF   = 8'h20;
  // Field positions
  localparam int unsigned SFB_CTRL_GO_BIT   = 0;
  localparam int unsigned SFB_CTRL_DUAL_BIT = 1;
  localparam int unsigned SFB_UCFG_DIS_BIT  = 0;
  // Reset values
  localparam logic [7:0] SFB_FROP_RST = 8'h3b;
  localparam logic [7:0] SFB_CLEN_RST = 8'h00;
  // Flash opcodes and addresses
  localparam logic [7:0]  SFB_OP_FAST_READ = 8'h0b;
  localparam logic [23:0] SFB_SIG_ADDR     = 24'h00fffa;
  localparam logic [23:0] SFB_DUAL_MASK    = 24'h01ffff;
  localparam logic [1:0]  SFB_SIG_LAST     = 2'h3;
  // Shift lengths and cache size
  localparam logic [5:0] SFB_HDR_BITS  = 6'h28;
  localparam logic [5:0] SFB_BYTE_BITS = 6'h08;
  localparam logic [5:0] SFB_DUAL_CLKS = 6'h04;
  localparam logic [5:0] SFB_CACHE_MAX = 6'h20;
  // Timing: flash clock rates and the cost of the input synchronisers
  localparam int unsigned SFB_PCLK_MHZ    = 50;
  localparam int unsigned SFB_RATE_LO_MHZ = 30;
  localparam int unsigned SFB_RATE_HI_MHZ = 60;
  localparam int unsigned SFB_SYNC_CYC    = 2;
  localparam int unsigned SFB_HALF_LO =
    (SFB_PCLK_MHZ + 2 * SFB_RATE_LO_MHZ - 1) / (2 * SFB_RATE_LO_MHZ) + SFB_SYNC_CYC;
  localparam int unsigned SFB_HALF_HI =
    (SFB_PCLK_MHZ + 2 * SFB_RATE_HI_MHZ - 1) / (2 * SFB_RATE_HI_MHZ) + SFB_SYNC_CYC;

  // Engine states
  typedef enum logic [2:0] {
    SFB_ST_IDLE = 3'b000,
    SFB_ST_HDR  = 3'b001,
    SFB_ST_DATA = 3'b010,
    SFB_ST_HOLD = 3'b011,
    SFB_ST_BUF  = 3'b100
  } sfb_state_t;

  // Code fetch request from the processor core
  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
  } sfb_fetch_req_t;

  // Code fetch answer to the processor core
  typedef struct packed {
    logic       ready;
    logic [7:0] data;
  } sfb_fetch_rsp_t;

  // Flash pins driven by the block
  typedef struct packed {
    logic sel_n;
    logic sck;
    logic io0_o;
    logic io0_oe;
  } sfb_flash_out_t;
endpackage : sfb_pkg

// >>> rtl/sfb_top.sv
// Contract
// - Boot signature at 0xFFFA picks flash execution
// - Port enabled after reset, software may disable
// - Single read: 0x0B, address, dummy, byte
// - First byte captured, ready pulse to core
// - Sequential address continues, other address deselects; a cache hit in hold keeps select low
// - Dual read: programmable opcode, 17-bit address
// - Dual data: two bits per clock
// - Cache base loads on jump, length grows
// - Base advances past 32 bytes
// - Cache hit answers in one clock
// - Command, response buffers and length register
// - Go bit: eight clocks per byte
// - Bytes after first stored in response
// - Beyond command buffer drive filler zeros
// - Select returns high at count end
// - Erase commands use four-byte length
// - Byte program uses five-byte length
// - Single-byte commands use length one
// - Identification read leaves three response bytes
// - Rate strap latched after reset
// - Flash checked first, runs entirely from it
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module sfb_top #(
  parameter logic [31:0] SIG_VALUE = 32'h32444655  // Boot signature text
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    clk_en,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire sfb_pkg::sfb_fetch_req_t fetch_req,
  output sfb_pkg::sfb_fetch_rsp_t      fetch_rsp,
  input  wire logic                    clock_rate_strap,
  input  wire logic                    serial_in_line,
  input  wire logic                    io0_in,
  output sfb_pkg::sfb_flash_out_t      flash_out,
  output logic                         boot_done,
  output logic                         boot_from_flash
);
  import sfb_pkg::*;

  // Control registers
  logic                go_ff;             // Buffered transfer pending
  logic                dual_ff;           // Dual data mode
  logic                port_dis_ff;       // Flash port disable
  logic [7:0]          fast_read_opcode_reg;
  logic [7:0]          command_length;
  logic [7:0]          cmd_buf_ff [8];
  logic [7:0]          response_buffer [8];
  logic [31:0]         prdata_ff;
  logic                pready_ff;
  logic                pslverr_ff;
  // Engine state
  sfb_state_t          st_ff;
  sfb_flash_out_t      flash_ff;
  sfb_fetch_rsp_t      rsp_ff;
  logic [39:0]         out_sr_ff;         // Outgoing bits, MSB on the line
  logic [7:0]          in_sr_ff;          // Incoming byte
  logic [5:0]          bits_ff;           // Clocks left in this phase
  logic [7:0]          byte_idx_ff;       // Byte number in a buffered transfer
  logic [23:0]         cur_addr_ff;       // Address of the byte in flight
  logic [23:0]         last_addr_ff;      // Address of the last byte read from flash
  logic [3:0]          div_ff;            // Flash clock half-period counter
  // Prefetch cache
  logic [7:0]          cache_ff [32];
  logic [23:0]         cache_base_ff;
  logic [5:0]          cache_len_ff;
  // Boot and strap
  logic                boot_done_ff;
  logic                boot_flash_ff;
  logic [1:0]          boot_cnt_ff;
  logic [23:0]         sig_ff;
  logic [1:0]          strap_sync_ff;
  logic                rate_ff;
  logic                rate_taken_ff;
  // Pin synchronisers
  logic [1:0]          si_sync_ff;
  logic [1:0]          io0_sync_ff;

  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign fetch_rsp       = rsp_ff;
  assign flash_out       = flash_ff;
  assign boot_done       = boot_done_ff;
  assign boot_from_flash = boot_flash_ff;

  // Byte of the command buffer, or filler once past its end
  function automatic logic [7:0] cmd_byte(input logic [7:0] idx);
    cmd_byte = (idx < 8'h08) ? cmd_buf_ff[idx[2:0]] : 8'h00;
  endfunction : cmd_byte

  // APB decode
  wire        apb_setup = psel & ~penable;
  wire        apb_wr    = psel & penable & pwrite & pready_ff;
  wire        addr_ok   = (paddr <= SFB_STAT_OFF) && (paddr[1:0] == 2'b00);
  wire        busy      = (st_ff != SFB_ST_IDLE);

  // Boot runs the read path with its own addresses
  wire        boot_act  = ~boot_done_ff;
  wire        req_valid = boot_act | (fetch_req.valid & boot_flash_ff);
  wire [23:0] req_addr  = boot_act ? (SFB_SIG_ADDR + {22'h0, boot_cnt_ff}) : fetch_req.addr;
  wire [23:0] eff_addr  = dual_ff ? (req_addr & SFB_DUAL_MASK) : req_addr;
  wire [7:0]  rd_opcode = dual_ff ? fast_read_opcode_reg : SFB_OP_FAST_READ;
  // A request is ignored in the cycle its answer is shown
  wire        take      = req_valid & ~rsp_ff.ready & ~port_dis_ff;
  wire        seq_hit   = (eff_addr == (last_addr_ff + 24'h000001));
  wire [23:0] cache_off = eff_addr - cache_base_ff;
  wire        cache_hit = (cache_off < {18'h0, cache_len_ff});
  wire        buf_start = go_ff & ~port_dis_ff & boot_done_ff;
  wire [3:0]  half_cyc  = rate_ff ? 4'(SFB_HALF_HI - 1) : 4'(SFB_HALF_LO - 1);
  wire        tick      = (div_ff == 4'h0);
  wire        rise      = tick & ~flash_ff.sck;
  wire        fall      = tick & flash_ff.sck;
  wire        si_s      = si_sync_ff[1];
  wire        io0_s     = io0_sync_ff[1];
  wire [7:0]  nxt_idx   = byte_idx_ff + 8'h01;
  wire [7:0]  nxt_cmd   = cmd_byte(nxt_idx);
  wire [31:0] stat_word = {18'h0, cache_len_ff, 3'h0, rate_ff, boot_flash_ff,
                           boot_done_ff, busy, go_ff};
  wire [31:0] rd_mux =
    (paddr == SFB_CTRL_OFF) ? {30'h0, dual_ff, go_ff} :
    (paddr == SFB_UCFG_OFF) ? {31'h0, port_dis_ff} :
    (paddr == SFB_FROP_OFF) ? {24'h0, fast_read_opcode_reg} :
    (paddr == SFB_CLEN_OFF) ? {24'h0, command_length} :
    (paddr == SFB_CMDL_OFF) ? {cmd_buf_ff[3], cmd_buf_ff[2], cmd_buf_ff[1], cmd_buf_ff[0]} :
    (paddr == SFB_CMDH_OFF) ? {cmd_buf_ff[7], cmd_buf_ff[6], cmd_buf_ff[5], cmd_buf_ff[4]} :
    (paddr == SFB_RSPL_OFF) ? {response_buffer[3], response_buffer[2],
                               response_buffer[1], response_buffer[0]} :
    (paddr == SFB_RSPH_OFF) ? {response_buffer[7], response_buffer[6],
                               response_buffer[5], response_buffer[4]} :
    (paddr == SFB_STAT_OFF) ? stat_word : 32'h0;

  // Two-flop synchronisers for pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      si_sync_ff    <= 2'h0;
      io0_sync_ff   <= 2'h0;
      strap_sync_ff <= 2'h0;
    end else if (clk_en) begin
      si_sync_ff    <= {si_sync_ff[0], serial_in_line};
      io0_sync_ff   <= {io0_sync_ff[0], io0_in};
      strap_sync_ff <= {strap_sync_ff[0], clock_rate_strap};
    end
  end

  // Strap caught once, in the first cycle after boot is done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_ff       <= 1'b0;
      rate_taken_ff <= 1'b0;
    end else if (clk_en && !rate_taken_ff && !boot_act) begin
      rate_ff       <= strap_sync_ff[1];
      rate_taken_ff <= 1'b1;
    end
  end

  // APB slave: zero wait, prdata prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else if (clk_en) begin
      pready_ff <= 1'b1;
      if (apb_setup) begin
        prdata_ff  <= pwrite ? 32'h0 : rd_mux;
        pslverr_ff <= ~addr_ok;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_ff                <= 1'b0;
      dual_ff              <= 1'b0;
      port_dis_ff          <= 1'b0;
      fast_read_opcode_reg <= SFB_FROP_RST;
      command_length       <= SFB_CLEN_RST;
      for (int i = 0; i < 8; i++) begin
        cmd_buf_ff[i] <= 8'h00;
      end
    end else if (clk_en) begin
      // Engine takes the go bit; a new write in that cycle wins
      if (buf_start && st_ff == SFB_ST_IDLE && !take) begin
        go_ff <= 1'b0;
      end
      if (apb_wr) begin
        unique case (paddr)
          SFB_CTRL_OFF: begin
            if (pwdata[SFB_CTRL_GO_BIT]) begin
              go_ff <= 1'b1;
            end
            dual_ff <= pwdata[SFB_CTRL_DUAL_BIT];
          end
          SFB_UCFG_OFF: port_dis_ff <= pwdata[SFB_UCFG_DIS_BIT];
          SFB_FROP_OFF: fast_read_opcode_reg <= pwdata[7:0];
          SFB_CLEN_OFF: command_length <= pwdata[7:0];
          SFB_CMDL_OFF: {cmd_buf_ff[3], cmd_buf_ff[2], cmd_buf_ff[1], cmd_buf_ff[0]} <= pwdata;
          SFB_CMDH_OFF: {cmd_buf_ff[7], cmd_buf_ff[6], cmd_buf_ff[5], cmd_buf_ff[4]} <= pwdata;
          default: begin
          end
        endcase
      end
    end
  end

  // Boot signature check on each delivered boot byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_done_ff  <= 1'b0;
      boot_flash_ff <= 1'b0;
      boot_cnt_ff   <= 2'h0;
      sig_ff        <= 24'h0;
    end else if (clk_en && boot_act) begin
      if (port_dis_ff) begin
        // Disabled port: fall back to internal memory
        boot_done_ff <= 1'b1;
      end else if (rsp_ff.ready) begin
        sig_ff      <= {sig_ff[15:0], rsp_ff.data};
        boot_cnt_ff <= boot_cnt_ff + 2'h1;
        if (boot_cnt_ff == SFB_SIG_LAST) begin
          boot_done_ff  <= 1'b1;
          boot_flash_ff <= ({sig_ff, rsp_ff.data} == SIG_VALUE);
        end
      end
    end
  end

  // Flash clock divider, restarted whenever the line is idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 4'h0;
    end else if (clk_en) begin
      div_ff <= (tick || st_ff == SFB_ST_IDLE || st_ff == SFB_ST_HOLD) ? half_cyc
                                                                      : div_ff - 4'h1;
    end
  end

  // Transfer engine: fetch reads, cache answers and buffered transfers.
  // Outputs change on falling flash clock edges so the flash sees stable
  // data at its rising edge; incoming bits are sampled at our rising edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff         <= SFB_ST_IDLE;
      flash_ff      <= '{sel_n: 1'b1, sck: 1'b0, io0_o: 1'b0, io0_oe: 1'b0};
      rsp_ff        <= '0;
      out_sr_ff     <= 40'h0;
      in_sr_ff      <= 8'h00;
      bits_ff       <= 6'h0;
      byte_idx_ff   <= 8'h00;
      cur_addr_ff   <= 24'h0;
      last_addr_ff  <= 24'h0;
      cache_base_ff <= 24'h0;
      cache_len_ff  <= 6'h0;
    end else if (clk_en) begin
      rsp_ff.ready <= 1'b0;
      unique case (st_ff)
        // Idle: select high, wait for work
        SFB_ST_IDLE: begin
          if (take && cache_hit) begin
            rsp_ff <= '{ready: 1'b1, data: cache_ff[eff_addr[4:0]]};
          end else if (take) begin
            cache_base_ff <= eff_addr;
            cache_len_ff  <= 6'h0;
            cur_addr_ff   <= eff_addr;
            out_sr_ff     <= {rd_opcode, eff_addr, 8'h00};
            bits_ff       <= SFB_HDR_BITS;
            flash_ff      <= '{sel_n: 1'b0, sck: 1'b0, io0_o: rd_opcode[7], io0_oe: 1'b1};
            st_ff         <= SFB_ST_HDR;
          end else if (buf_start && command_length != 8'h00) begin
            out_sr_ff   <= {cmd_byte(8'h00), 32'h0};
            bits_ff     <= SFB_BYTE_BITS;
            byte_idx_ff <= 8'h00;
            flash_ff    <= '{sel_n: 1'b0, sck: 1'b0, io0_o: cmd_buf_ff[0][7], io0_oe: 1'b1};
            st_ff       <= SFB_ST_BUF;
          end
        end
        // Header: opcode, address and dummy byte, MSB first
        SFB_ST_HDR: begin
          if (port_dis_ff) begin
            flash_ff <= '{sel_n: 1'b1, sck: 1'b0, io0_o: 1'b0, io0_oe: 1'b0};
            st_ff    <= SFB_ST_IDLE;
          end else if (rise) begin
            flash_ff.sck <= 1'b1;
          end else if (fall) begin
            flash_ff.sck   <= 1'b0;
            out_sr_ff      <= {out_sr_ff[38:0], 1'b0};
            flash_ff.io0_o <= out_sr_ff[38];
            bits_ff        <= bits_ff - 6'h1;
            if (bits_ff == 6'h1) begin
              // Data phase; dual mode releases io0 for the flash
              flash_ff.io0_oe <= ~dual_ff;
              bits_ff         <= dual_ff ? SFB_DUAL_CLKS : SFB_BYTE_BITS;
              st_ff           <= SFB_ST_DATA;
            end
          end
        end
        // Data: one byte in over eight or four clocks
        SFB_ST_DATA: begin
          if (port_dis_ff) begin
            flash_ff <= '{sel_n: 1'b1, sck: 1'b0, io0_o: 1'b0, io0_oe: 1'b0};
            st_ff    <= SFB_ST_IDLE;
          end else if (rise) begin
            flash_ff.sck <= 1'b1;
            in_sr_ff     <= dual_ff ? {in_sr_ff[5:0], si_s, io0_s} : {in_sr_ff[6:0], si_s};
          end else if (fall) begin
            flash_ff.sck <= 1'b0;
            bits_ff      <= bits_ff - 6'h1;
            if (bits_ff == 6'h1) begin
              rsp_ff       <= '{ready: 1'b1, data: in_sr_ff};
              last_addr_ff <= cur_addr_ff;
              cache_ff[cur_addr_ff[4:0]] <= in_sr_ff;
              if (cache_len_ff < SFB_CACHE_MAX) begin
                cache_len_ff <= cache_len_ff + 6'h1;
              end else begin
                cache_base_ff <= cache_base_ff + 24'h000001;
              end
              st_ff <= SFB_ST_HOLD;
            end
          end
        end
        // Hold: select stays low while addresses run on
        SFB_ST_HOLD: begin
          if (port_dis_ff || go_ff) begin
            flash_ff <= '{sel_n: 1'b1, sck: 1'b0, io0_o: 1'b0, io0_oe: 1'b0};
            st_ff    <= SFB_ST_IDLE;
          end else if (take && seq_hit) begin
            cur_addr_ff <= eff_addr;
            bits_ff     <= dual_ff ? SFB_DUAL_CLKS : SFB_BYTE_BITS;
            st_ff       <= SFB_ST_DATA;
          end else if (take && cache_hit) begin
            rsp_ff <= '{ready: 1'b1, data: cache_ff[eff_addr[4:0]]};
          end else if (take) begin
            flash_ff <= '{sel_n: 1'b1, sck: 1'b0, io0_o: 1'b0, io0_oe: 1'b0};
            st_ff    <= SFB_ST_IDLE;
          end
        end
        // Buffered transfer: length bytes, eight clocks each;
        // command kinds differ only in buffer contents and length
        // lengths from software
        SFB_ST_BUF: begin
          if (port_dis_ff) begin
            flash_ff <= '{sel_n: 1'b1, sck: 1'b0, io0_o: 1'b0, io0_oe: 1'b0};
            st_ff    <= SFB_ST_IDLE;
          end else if (rise) begin
            flash_ff.sck <= 1'b1;
            in_sr_ff     <= {in_sr_ff[6:0], si_s};
          end else if (fall) begin
            flash_ff.sck   <= 1'b0;
            out_sr_ff      <= {out_sr_ff[38:0], 1'b0};
            flash_ff.io0_o <= out_sr_ff[38];
            bits_ff        <= bits_ff - 6'h1;
            if (bits_ff == 6'h1) begin
              if (byte_idx_ff != 8'h00 && byte_idx_ff <= 8'h08) begin
                response_buffer[3'(byte_idx_ff - 8'h01)] <= in_sr_ff;
              end
              if (nxt_idx >= command_length) begin
                flash_ff <= '{sel_n: 1'b1, sck: 1'b0, io0_o: 1'b0, io0_oe: 1'b0};
                st_ff    <= SFB_ST_IDLE;
              end else begin
                byte_idx_ff    <= nxt_idx;
                out_sr_ff      <= {nxt_cmd, 32'h0};
                flash_ff.io0_o <= nxt_cmd[7];
                bits_ff        <= SFB_BYTE_BITS;
              end
            end
          end
        end
        default: begin
          flash_ff <= '{sel_n: 1'b1, sck: 1'b0, io0_o: 1'b0, io0_oe: 1'b0};
          st_ff    <= SFB_ST_IDLE;
        end
      endcase
    end
  end
endmodule : sfb_top
`default_nettype wire

// >>> verif/sfb_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sfb_properties (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             prdata,
  input wire logic                    pslverr,
  input wire sfb_pkg::sfb_fetch_rsp_t fetch_rsp,
  input wire sfb_pkg::sfb_flash_out_t flash_out,
  input wire logic                    boot_done,
  input wire logic                    boot_from_flash
);
  import sfb_pkg::*;
  // Beyond the map or not word aligned
  wire logic bad_addr;
  assign bad_addr = paddr > SFB_STAT_OFF || paddr[1:0] != 2'b00;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_rdy_pulse: assert property (fetch_rsp.ready |=> !fetch_rsp.ready)
    else $error("fetch ready held over one cycle");
  chk_rdy_boot: assert property (fetch_rsp.ready && boot_done |-> boot_from_flash)
    else $error("fetch answered without flash boot");
  chk_boot_keep: assert property (boot_done |=> boot_done && $stable(boot_from_flash))
    else $error("boot result changed");
  chk_sck_high: assert property ($rose(flash_out.sck) |-> flash_out.sck [*3] ##1 !flash_out.sck)
    else $error("flash clock high phase wrong");
  chk_sel_start: assert property ($fell(flash_out.sel_n) |-> !flash_out.sck [*3] ##1 flash_out.sck)
    else $error("first flash clock misplaced");
  chk_sck_idle: assert property (flash_out.sel_n |-> !flash_out.sck)
    else $error("flash clock runs while deselected");
  chk_io_fall: assert property (!flash_out.sel_n && $past(!flash_out.sel_n) && flash_out.io0_oe
    && $past(flash_out.io0_oe) && $changed(flash_out.io0_o) |-> $fell(flash_out.sck))
    else $error("serial out changed off the falling clock");
  chk_bad_addr: assert property (psel && !penable && bad_addr |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_good_addr: assert property (psel && !penable && !bad_addr |=> !pslverr)
    else $error("mapped access refused");
endmodule : sfb_properties
bind sfb_top sfb_properties u_sfb_properties (.pclk, .presetn, .psel, .penable, .paddr,
  .prdata, .pslverr, .fetch_rsp, .flash_out, .boot_done, .boot_from_flash);
`default_nettype wire

// >>> verif/sfb_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module sfb_flash_model (
  input  wire logic                    pclk,
  input  wire sfb_pkg::sfb_flash_out_t flash_out,
  output logic                         serial_in_line,
  output logic                         io0_drv
);
  import sfb_pkg::*;
  localparam logic [31:0] SIG = 32'h32444655; // Boot signature text
  localparam logic [7:0]  ID0 = 8'h3c;        // Arbitrary identity byte base
  logic [7:0]  op_ff, b;                      // Opcode, byte being answered
  logic [23:0] adr_ff;                        // Received start address
  logic [31:0] sh_ff;                         // Input shifter
  logic        sck_q, pend, dual, ans;
  int          c, j, k;                       // Rises in frame, data bit, bit offset
  // Contents: signature below 64 KB, a pattern elsewhere
  function automatic logic [7:0] mem(input logic [23:0] a);
    if (a >= SFB_SIG_ADDR && a <= SFB_SIG_ADDR + 24'h3)
      return 8'(SIG >> (8 * (SFB_SIG_ADDR + 24'h3 - a)));
    return a[7:0] ^ a[23:16] ^ 8'ha5;
  endfunction : mem
  // Which byte and bit the next sample takes
  always_comb begin
    dual = op_ff == 8'h3b;
    j = (op_ff == 8'h9f) ? c - 8 : c - 40;
    k = dual ? 2 * (j % 4) : j % 8;
    ans = j >= 0 && (op_ff == 8'h0b || dual || op_ff == 8'h9f);
    b = (op_ff == 8'h9f) ? ID0 + 8'(j / 8) : mem(adr_ff + 24'(dual ? j / 4 : j / 8));
  end
  initial begin
    serial_in_line = 1'b0;
    io0_drv = 1'b0;
  end
  // Answer a pclk after the rise, hold to the next; idle lines never rest
  always @(posedge pclk) begin
    sck_q <= flash_out.sck;
    pend <= flash_out.sck && !sck_q && !flash_out.sel_n;
    if (flash_out.sel_n) begin
      c <= 0;
    end else if (flash_out.sck && !sck_q) begin
      sh_ff <= {sh_ff[30:0], flash_out.io0_o};
      c <= c + 1;
      if (c == 7) op_ff <= {sh_ff[6:0], flash_out.io0_o};
      if (c == 31) adr_ff <= {sh_ff[22:0], flash_out.io0_o};
    end
    if (pend && ans) begin
      serial_in_line <= b[7 - k];
      io0_drv <= dual ? b[6 - k] : ~io0_drv;
    end else if (!ans) begin
      serial_in_line <= ~serial_in_line;
      io0_drv <= ~io0_drv;
    end
  end
endmodule : sfb_flash_model
`default_nettype wire

// >>> verif/serial_flash_boot_controller_test.sv
`timescale 1ns/100ps
`default_nettype none
module serial_flash_boot_controller_test;
  import sfb_pkg::*;
  localparam logic [7:0] ONE_BYTE_OP = 8'h06; // Any one-byte command
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic           boot_done, boot_from_flash, so, m_io0, sck_q, strap;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, rd;
  logic [23:0]    msk = 24'hffffff;           // Address bits the flash sees
  sfb_fetch_req_t fetch_req;
  sfb_fetch_rsp_t fetch_rsp;
  sfb_flash_out_t flash_out;
  wire logic      io0_w;
  int             n_fail = 0, n_compared = 0, n_sck = 0, n_rdy = 0, cyc = 0, lat, s0;
  logic [7:0]     ops [7] = '{8'h20, 8'h52, 8'hd8, 8'h02, ONE_BYTE_OP, 8'h9f, ONE_BYTE_OP};
  int             lens [7] = '{4, 4, 4, 5, 1, 4, 9};
  // Shared io0: block drives while enabled, else the flash
  assign io0_w = flash_out.io0_oe ? flash_out.io0_o : m_io0;
  sfb_top u_sfb_top (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fetch_req, .fetch_rsp, .clock_rate_strap(strap),
    .serial_in_line(so), .io0_in(io0_w), .flash_out, .boot_done, .boot_from_flash);
  sfb_flash_model u_sfb_flash_model (.pclk, .flash_out, .serial_in_line(so), .io0_drv(m_io0));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Flash clock and ready counters, hang guard
  always @(posedge pclk) begin
    sck_q <= flash_out.sck;
    if (flash_out.sck && !sck_q) n_sck <= n_sck + 1;
    if (fetch_rsp.ready === 1'b1) n_rdy <= n_rdy + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int t;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 1'b0;
    @(posedge pclk) penable <= 1'b1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 100);
    r = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd, err);
    chk(nm, e, rd & m);
  endtask : rdc
  // Sequential core fetches, latency of the first kept
  task automatic run(input logic [23:0] a, input int n, output int l);
    int t;
    logic [23:0] x;
    for (int i = 0; i < n; i++) begin
      fetch_req <= '{1'b1, a + 24'(i)};
      t = 0;
      do begin @(posedge pclk); t++; end while (fetch_rsp.ready !== 1'b1 && t < 3000);
      if (i == 0) l = t;
      x = (a + 24'(i)) & msk;
      chk("fetch data", 32'(x[7:0] ^ x[23:16] ^ 8'ha5), 32'(fetch_rsp.data));
    end
    fetch_req.valid <= 1'b0;
    @(posedge pclk);
  endtask : run
  // Buffered command, then count its clocks
  task automatic cmd(input logic [7:0] op, input int n);
    int c0;
    wr(SFB_CMDL_OFF, {24'h123456, op});
    wr(SFB_CLEN_OFF, 32'(n));
    c0 = n_sck;
    wr(SFB_CTRL_OFF, 32'h1);
    for (int i = 0; i < 1000; i++) begin
      apb(1'b0, SFB_STAT_OFF, 32'h0, rd, err);
      if (rd[1:0] === 2'b00) break;
    end
    chk("clock count", 32'(8 * n), 32'(n_sck - c0));
    chk("select idle", 32'h1, 32'(flash_out.sel_n));
    if (op == 8'h9f && n == 4) rdc("id bytes", SFB_RSPL_OFF, 32'hffffff, 32'h3e3d3c);
  endtask : cmd
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; fetch_req = '0; sck_q = 1'b0; strap = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3000 && boot_done !== 1'b1; i++) @(posedge pclk);
    chk("boot from flash", 32'h1, 32'(boot_from_flash));
    rdc("status boot", SFB_STAT_OFF, 32'h1c, 32'h1c);
    rdc("opcode reset", SFB_FROP_OFF, 32'hff, 32'h3b);
    rdc("length reset", SFB_CLEN_OFF, 32'hff, 32'h00);
    apb(1'b0, 8'h24, 32'h0, rd, err);
    chk("unmapped refused", 32'h1, 32'(err));
    run(24'h000000, 3, lat);
    chk("miss slow", 32'h1, 32'(lat > 100));
    run(24'h000001, 1, lat);
    chk("hit fast", 32'h1, 32'(lat <= 2));
    run(24'h000100, 40, lat);
    run(24'h000108, 1, lat);
    chk("oldest kept", 32'h1, 32'(lat <= 2));
    run(24'h000107, 1, lat);
    chk("dropped byte", 32'h1, 32'(lat > 100));
    for (int i = 0; i < 7; i++) cmd(ops[i], lens[i]);
    wr(SFB_CTRL_OFF, 32'h2);
    msk = SFB_DUAL_MASK;
    run(24'hff2345, 2, lat);
    wr(SFB_UCFG_OFF, 32'h1);
    s0 = n_rdy;
    fetch_req <= '{1'b1, 24'h000300};
    repeat (300) @(posedge pclk);
    chk("fetch while off", 32'h0, 32'(n_rdy - s0));
    chk("select off", 32'h1, 32'(flash_out.sel_n));
    give_verdict();
  end
endmodule : serial_flash_boot_controller_test
`default_nettype wire
